// ---- src/ptc_pkg.sv ----
// Constants for the PWM timer control, clock select and interrupt block
package ptc_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [15:0] CMP_A_IDX = 16'h5300;
  localparam logic [15:0] CMP_B_IDX = 16'h5302;
  localparam logic [15:0] COUNT_IDX = 16'h5304;
  localparam logic [15:0] CTL_IDX = 16'h5306;
  localparam logic [15:0] CLK_SEL_IDX = 16'h5308;
  localparam logic [15:0] IRQ_MASK_IDX = 16'h530A;
  localparam logic [15:0] IRQ_FLAG_IDX = 16'h530C;

  // ==========================================================
  // Control register fields
  localparam int CTL_RUN = 0;
  localparam int CTL_CLR = 1;
  localparam int CTL_OUT_EN = 2;
  localparam int CTL_SRC = 3;
  localparam int CTL_INV = 4;
  localparam int CTL_IDLE = 8;
  localparam logic [15:0] CTL_WMASK = 16'h011D;
  localparam logic [15:0] CTL_RST = 16'h0000;

  // ==========================================================
  // Clock select, mask and flag fields
  localparam int TAP_W = 4;
  localparam int DIV_W = 14;
  localparam logic [3:0] TAP_RESERVED = 4'hF;
  localparam logic [3:0] TAP_RST = 4'h0;
  localparam int IRQ_A = 0;
  localparam int IRQ_B = 1;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] FLAG_RST = 2'h0;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- src/ptc_prescaler.sv ----
// Free-running prescaler with a selectable power-of-two tap
`timescale 1ns/1ns
module ptc_prescaler #(
  parameter int TAP_W = ptc_pkg::TAP_W,
  parameter int DIV_W = ptc_pkg::DIV_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [TAP_W-1:0] tap,
  output logic tick
);

  // ==========================================================
  // Elaboration check
  if (DIV_W >= (1 << TAP_W) || DIV_W < 1) begin : g_bad
    $error("ptc_prescaler: DIV_W must be below 2**TAP_W");
  end

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
  } ptc_pre_t;

  ptc_pre_t s;
  ptc_pre_t next_s;
  logic [DIV_W-1:0] low_mask;

  // ==========================================================
  // Tick when the low tap bits of the divider are all ones
  always_comb begin
    next_s = s;
    low_mask = ~({DIV_W{1'b1}} << tap);
    next_s.div = s.div + 1'b1;
    next_s.tick = (tap <= TAP_W'(DIV_W)) && ((s.div & low_mask) == low_mask);
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  // Tap zero ticks on every cycle, once a cycle out of reset has passed
  tap_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
    nrst && (tap == '0) ##1 (tap == '0) |-> tick)
    else $error("tap 0 missed tick");

endmodule

// ---- src/ptc_timer_ctl.sv ----
// PWM timer control, count clock select, waveform pin and compare interrupts
//
// Contract
// - Source bit 0 counts prescaler ticks; 1 counts external pin rising edges.
// - Output enable 1 drives the timer waveform onto the output pin.
// - Output enable 0 holds the pin at the off level from invert and idle.
// - Writing 1 to clear bit D1 resets the counter; bit reads 0.
// - Run bit D0 starts counting when 1, stops when 0; resets to 0.
// - Stopped counter keeps its value; run resumes from the kept value.
// - Tap code selects clock divided by two to the code; 0xF reserved.
// - Compare B enable at D1 gates the compare B interrupt; resets 0.
// - Compare A enable at D0 gates the compare A interrupt; resets 0.
// - Flags B at D1, A at D0; set on cause, reset 0, write 1 or a flag register read clears.
// - Counter equal to compare B while counting, enabled, sets flag B.
// - Counter equal to compare A while counting, enabled, sets flag A.
// - Invert 1 gives active low output; 0 gives active high output.
`timescale 1ns/1ns
module ptc_timer_ctl #(
  parameter int ADDR_W = 18
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic external_count_clock_pin,
  output logic timer_waveform_output,
  output logic compare_irq
);

  localparam int IW = ADDR_W - 2;

  // ==========================================================
  // Elaboration check
  if (ADDR_W < 18) begin : g_bad
    $error("ptc_timer_ctl: ADDR_W must be at least 18");
  end

  typedef struct packed {
    logic aw_held;
    logic [IW-1:0] aw_idx;
    logic w_held;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] ctl;
    logic [3:0] tap;
    logic [1:0] mask;
    logic [1:0] flags;
    logic [15:0] count;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic wave;
    logic pin;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
  } ptc_state_t;

  ptc_state_t s;
  ptc_state_t next_s;
  logic pre_tick;
  logic ext_edge;
  logic tick;
  logic wr_fire;
  logic rd_fire;
  logic [IW-1:0] rd_idx;
  logic match_a;
  logic match_b;
  logic clr_w;
  logic cnt_w;
  logic [1:0] flag_clr;
  logic [1:0] flag_set;

  // ==========================================================
  // Prescaler
  ptc_prescaler #(
    .TAP_W(ptc_pkg::TAP_W),
    .DIV_W(ptc_pkg::DIV_W)
  ) u_pre (
    .core_clk(core_clk),
    .nrst(nrst),
    .tap(s.tap),
    .tick(pre_tick)
  );

  // Merge a 16-bit write under the two low byte strobes
  function automatic logic [15:0] ptc_merge(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0] strb);
    ptc_merge = {strb[1] ? wd[15:8] : old[15:8],
                 strb[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // Count source, compare matches and bus strobes
  assign ext_edge = s.ext_s2 & ~s.ext_s3;
  assign tick = s.ctl[ptc_pkg::CTL_SRC] ? ext_edge : pre_tick;
  assign match_a = s.ctl[ptc_pkg::CTL_RUN] && tick
                   && (s.count == s.cmp_a);
  assign match_b = s.ctl[ptc_pkg::CTL_RUN] && tick
                   && (s.count == s.cmp_b);
  assign wr_fire = s.aw_held && s.w_held && !s.bvalid;
  assign rd_fire = s_axi_arvalid && !s.rvalid;
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];
  assign clr_w = wr_fire && s.aw_idx == IW'(ptc_pkg::CTL_IDX)
                 && s.wstrb[0] && s.wdata[ptc_pkg::CTL_CLR];
  assign cnt_w = wr_fire && s.aw_idx == IW'(ptc_pkg::COUNT_IDX);

  // Handshake, waveform pin and interrupt outputs
  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready = !s.w_held && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign timer_waveform_output = s.pin;
  assign compare_irq = |(s.flags & s.mask);

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_s = s;
    flag_clr = 2'h0;
    flag_set = {match_b & s.mask[ptc_pkg::IRQ_B],
                match_a & s.mask[ptc_pkg::IRQ_A]};
    // External pin synchroniser and edge history
    next_s.ext_s1 = external_count_clock_pin;
    next_s.ext_s2 = s.ext_s1;
    next_s.ext_s3 = s.ext_s2;
    // Address and data capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata[15:0];
      next_s.wstrb = s_axi_wstrb[1:0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    // Register writes
    if (wr_fire) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = ptc_pkg::RESP_OKAY;
      case (s.aw_idx)
        IW'(ptc_pkg::CMP_A_IDX): begin
          next_s.cmp_a = ptc_merge(s.cmp_a, s.wdata, s.wstrb);
        end
        IW'(ptc_pkg::CMP_B_IDX): begin
          next_s.cmp_b = ptc_merge(s.cmp_b, s.wdata, s.wstrb);
        end
        IW'(ptc_pkg::COUNT_IDX): begin
        end
        IW'(ptc_pkg::CTL_IDX): begin
          next_s.ctl = ptc_merge(s.ctl, s.wdata, s.wstrb)
                       & ptc_pkg::CTL_WMASK;
        end
        IW'(ptc_pkg::CLK_SEL_IDX): begin
          if (s.wstrb[0]) begin
            next_s.tap = s.wdata[3:0];
          end
        end
        IW'(ptc_pkg::IRQ_MASK_IDX): begin
          if (s.wstrb[0]) begin
            next_s.mask = s.wdata[1:0];
          end
        end
        IW'(ptc_pkg::IRQ_FLAG_IDX): begin
          if (s.wstrb[0]) begin
            flag_clr = s.wdata[1:0];
          end
        end
        default: begin
          next_s.bresp = ptc_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Register reads
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = ptc_pkg::RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      case (rd_idx)
        IW'(ptc_pkg::CMP_A_IDX): begin
          next_s.rdata[15:0] = s.cmp_a;
        end
        IW'(ptc_pkg::CMP_B_IDX): begin
          next_s.rdata[15:0] = s.cmp_b;
        end
        IW'(ptc_pkg::COUNT_IDX): begin
          next_s.rdata[15:0] = s.count;
        end
        IW'(ptc_pkg::CTL_IDX): begin
          next_s.rdata[15:0] = s.ctl;
        end
        IW'(ptc_pkg::CLK_SEL_IDX): begin
          next_s.rdata[3:0] = s.tap;
        end
        IW'(ptc_pkg::IRQ_MASK_IDX): begin
          next_s.rdata[1:0] = s.mask;
        end
        IW'(ptc_pkg::IRQ_FLAG_IDX): begin
          next_s.rdata[1:0] = s.flags;
          flag_clr = flag_clr | s.flags;
        end
        default: begin
          next_s.rresp = ptc_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Sticky flags, a new cause beats a clear
    next_s.flags = (s.flags & ~flag_clr) | flag_set;
    // Counter: clear, load, count or hold
    if (clr_w) begin
      next_s.count = ptc_pkg::COUNT_RST;
      next_s.wave = next_s.ctl[ptc_pkg::CTL_IDLE];
    end else if (cnt_w) begin
      next_s.count = ptc_merge(s.count, s.wdata, s.wstrb);
    end else if (s.ctl[ptc_pkg::CTL_RUN] && tick) begin
      next_s.count = match_b ? ptc_pkg::COUNT_RST : s.count + 16'h0001;
    end
    // Waveform rises on compare A, falls on compare B
    if (!clr_w && match_b) begin
      next_s.wave = 1'b0;
    end else if (!clr_w && match_a) begin
      next_s.wave = 1'b1;
    end
    // Output pin: waveform when enabled, else off level
    if (next_s.ctl[ptc_pkg::CTL_OUT_EN]) begin
      next_s.pin = next_s.wave ^ next_s.ctl[ptc_pkg::CTL_INV];
    end else begin
      next_s.pin = next_s.ctl[ptc_pkg::CTL_IDLE]
                   ^ next_s.ctl[ptc_pkg::CTL_INV];
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '0;
      s.ctl <= ptc_pkg::CTL_RST;
      s.tap <= ptc_pkg::TAP_RST;
      s.mask <= ptc_pkg::MASK_RST;
      s.flags <= ptc_pkg::FLAG_RST;
      s.count <= ptc_pkg::COUNT_RST;
      s.cmp_a <= ptc_pkg::CMP_RST;
      s.cmp_b <= ptc_pkg::CMP_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  clear_zeroes_count_a: assert property (
    clr_w |=> (s.count == 16'h0000)) else $error("clear missed");

  clear_reads_zero_a: assert property (
    s.ctl[ptc_pkg::CTL_CLR] == 1'b0) else $error("clear bit stored");

  stop_holds_a: assert property (
    !s.ctl[ptc_pkg::CTL_RUN] && !clr_w && !cnt_w |=> $stable(s.count))
    else $error("stopped counter moved");

  run_counts_a: assert property (
    s.ctl[ptc_pkg::CTL_RUN] && tick && !match_b && !clr_w && !cnt_w
    |=> s.count == $past(s.count) + 16'h0001)
    else $error("counter did not step");

  ext_source_a: assert property (
    s.ctl[ptc_pkg::CTL_SRC] && !ext_edge && !clr_w && !cnt_w
    |=> $stable(s.count)) else $error("counted without pin edge");

  pin_drive_a: assert property (
    s.ctl[ptc_pkg::CTL_OUT_EN]
    |-> s.pin == (s.wave ^ s.ctl[ptc_pkg::CTL_INV]))
    else $error("pin not driving waveform");

  pin_off_level_a: assert property (
    !s.ctl[ptc_pkg::CTL_OUT_EN] ##1 !s.ctl[ptc_pkg::CTL_OUT_EN]
    |-> s.pin == (s.ctl[ptc_pkg::CTL_IDLE] ^ s.ctl[ptc_pkg::CTL_INV]))
    else $error("pin not at off level");

  // A mask write in the match cycle may drop the request, never the flag
  flag_b_set_a: assert property (
    match_b && s.mask[ptc_pkg::IRQ_B]
    |=> s.flags[ptc_pkg::IRQ_B] && (compare_irq || !s.mask[ptc_pkg::IRQ_B]))
    else $error("compare B flag missed");

  flag_a_set_a: assert property (
    match_a && s.mask[ptc_pkg::IRQ_A]
    |=> s.flags[ptc_pkg::IRQ_A] && (compare_irq || !s.mask[ptc_pkg::IRQ_A]))
    else $error("compare A flag missed");

  masked_no_flag_a: assert property (
    !s.flags[ptc_pkg::IRQ_A] && !s.mask[ptc_pkg::IRQ_A]
    |=> !s.flags[ptc_pkg::IRQ_A]) else $error("masked flag set");

  flag_w1c_a: assert property (
    wr_fire && s.aw_idx == IW'(ptc_pkg::IRQ_FLAG_IDX) && s.wstrb[0]
    && s.wdata[0] && !match_a |=> !s.flags[ptc_pkg::IRQ_A])
    else $error("write one did not clear");

  reserved_zero_a: assert property (
    s.rvalid |-> s.rdata[31:16] == 16'h0000)
    else $error("reserved bits nonzero");

  match_a_cov: cover property (match_a && s.mask[ptc_pkg::IRQ_A]);
  match_b_cov: cover property (match_b && s.mask[ptc_pkg::IRQ_B]);
  ext_count_cov: cover property (s.ctl[ptc_pkg::CTL_SRC] && ext_edge
                                 && s.ctl[ptc_pkg::CTL_RUN]);
  irq_clear_cov: cover property (compare_irq ##1 !compare_irq);

endmodule

// ---- dv/pwm_timer_control_irq_test.sv ----
// Self-checking bench for the PWM timer control and interrupt block
`timescale 1ns/1ns
module pwm_timer_control_irq_test;
  // ==========================================================
  // Signals, register aliases and the design
  localparam logic [15:0] CA = ptc_pkg::CMP_A_IDX;
  localparam logic [15:0] CB = ptc_pkg::CMP_B_IDX;
  localparam logic [15:0] CNT = ptc_pkg::COUNT_IDX;
  localparam logic [15:0] CTL = ptc_pkg::CTL_IDX;
  localparam logic [15:0] CSEL = ptc_pkg::CLK_SEL_IDX;
  localparam logic [15:0] MSK = ptc_pkg::IRQ_MASK_IDX;
  localparam logic [15:0] FLG = ptc_pkg::IRQ_FLAG_IDX;
  localparam logic [15:0] RUN = 16'h0001 << ptc_pkg::CTL_RUN;
  localparam logic [15:0] CLR = 16'h0001 << ptc_pkg::CTL_CLR;
  localparam logic [15:0] OEN = 16'h0001 << ptc_pkg::CTL_OUT_EN;
  localparam logic [15:0] SRC = 16'h0001 << ptc_pkg::CTL_SRC;
  localparam logic [15:0] INV = 16'h0001 << ptc_pkg::CTL_INV;
  localparam logic [15:0] IDL = 16'h0001 << ptc_pkg::CTL_IDLE;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic ext = 1'b0;
  logic awr, wr_rdy, bv, arr, rv, pin, irq;
  logic [17:0] awa = 18'h00000, ara = 18'h00000;
  logic [31:0] wd = 32'h00000000, rd;
  logic [3:0] ws = 4'h0;
  logic [1:0] br, rr, resp;
  int bad_count = 0, n_checks = 0;

  ptc_timer_ctl i_dut (.core_clk(core_clk), .nrst(nrst),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .s_axi_rdata(rd), .s_axi_rresp(rr),
    .external_count_clock_pin(ext), .timer_waveform_output(pin),
    .compare_irq(irq));

  // ==========================================================
  // Clock and watchdog
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    $display("wrong value watchdog expected done seen hang");
    give_verdict();
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  // Bus write, both channels offered together, held until taken
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    awa <= {idx, 2'b00};
    wd <= {16'h0000, d};
    ws <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (!bv && n < 200);
    bry <= 1'b0;
    resp = br;
    chk("write answer", 1, n < 200);
  endtask

  // Bus read, data taken at the edge where rvalid is seen
  task automatic rdr(input logic [15:0] idx, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge core_clk);
    ara <= {idx, 2'b00};
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && n < 200);
    rry <= 1'b0;
    v = rd;
    resp = rr;
    chk("read answer", 1, n < 200);
  endtask

  task automatic rc(input string what, input logic [15:0] idx,
                    input logic [31:0] exp);
    logic [31:0] v;
    rdr(idx, v);
    chk(what, exp, v);
  endtask

  // Run for a while, then stop with the given other control bits
  task automatic run_for(input int n, input logic [15:0] bits);
    wr(CTL, RUN | bits);
    repeat (n) @(posedge core_clk);
    wr(CTL, bits);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rc("clock select", CSEL, 32'h00000000);
    rc("irq mask", MSK, 32'h00000000);
    rc("irq flags", FLG, 32'h00000000);
    rc("control", CTL, 32'h00000000);
    chk("irq", 0, irq);
    $display("test reset values done");
  endtask

  task automatic t_reserved();
    logic [31:0] v;
    wr(CSEL, 16'hFFFF);
    rc("clock select", CSEL, 32'h0000000F);
    wr(MSK, 16'hFFFC);
    rc("irq mask", MSK, 32'h00000000);
    wr(FLG, 16'hFFFF);
    rc("irq flags", FLG, 32'h00000000);
    wr(CSEL, 16'h0000);
    rdr(16'h5310, v);
    chk("unmapped read resp", 32'(ptc_pkg::RESP_SLVERR), 32'(resp));
    wr(16'h5310, 16'h1234);
    chk("unmapped write resp", 32'(ptc_pkg::RESP_SLVERR), 32'(resp));
    $display("test reserved bits done");
  endtask

  task automatic t_run_stop();
    logic [31:0] c1, c2;
    wr(CA, 16'hFFFF);
    wr(CB, 16'hFFFF);
    wr(CTL, CLR);
    rc("count after clear", CNT, 32'h00000000);
    run_for(10, 16'h0000);
    rdr(CNT, c1);
    chk("counting while run", 1, c1 > 0);
    repeat (10) @(posedge core_clk);
    rc("held count", CNT, c1);
    run_for(4, 16'h0000);
    rdr(CNT, c2);
    chk("resumed count", 1, c2 > c1 && c2 < c1 + 16);
    wr(CTL, CLR);
    rc("clear bit reads", CTL, 32'h00000000);
    rc("count after clear", CNT, 32'h00000000);
    $display("test run and stop done");
  endtask

  task automatic t_tap();
    logic [31:0] c;
    for (int k = 0; k < 4; k++) begin
      wr(CSEL, 16'(k));
      wr(CTL, CLR);
      run_for(64, 16'h0000);
      rdr(CNT, c);
      chk("tap count", 1, c >= (64 >> k) && c <= (72 >> k) + 1);
    end
    wr(CSEL, 16'h000F);
    wr(CTL, CLR);
    run_for(40, 16'h0000);
    rc("reserved tap count", CNT, 32'h00000000);
    wr(CSEL, 16'h0000);
    $display("test prescaler taps done");
  endtask

  task automatic t_ext();
    wr(CTL, SRC | CLR);
    wr(CTL, SRC | RUN);
    repeat (10) begin
      repeat (4) @(posedge core_clk);
      ext <= ~ext;
    end
    repeat (5) @(posedge core_clk);
    wr(CTL, SRC);
    rc("event count", CNT, 32'h00000005);
    wr(CTL, 16'h0000);
    $display("test external count done");
  endtask

  task automatic t_irq();
    wr(CA, 16'h0002);
    wr(CB, 16'h0004);
    wr(CTL, CLR);
    wr(MSK, 16'h0000);
    run_for(20, 16'h0000);
    chk("irq masked", 0, irq);
    rc("flags masked", FLG, 32'h00000000);
    wr(MSK, 16'h0001);
    run_for(20, 16'h0000);
    rc("flag a only", FLG, 32'h00000001);
    wr(MSK, 16'h0002);
    run_for(20, 16'h0000);
    chk("irq b", 1, irq);
    rc("flag b only", FLG, 32'h00000002);
    wr(MSK, 16'h0003);
    run_for(20, 16'h0000);
    wr(FLG, 16'h0000);
    chk("irq after write 0", 1, irq);
    wr(FLG, 16'h0001);
    chk("irq with b left", 1, irq);
    wr(FLG, 16'h0002);
    chk("irq after clear", 0, irq);
    rc("flags cleared", FLG, 32'h00000000);
    wr(MSK, 16'h0000);
    $display("test interrupts done");
  endtask

  task automatic t_pin();
    logic [15:0] cb;
    int n;
    for (int i = 0; i < 4; i++) begin
      cb = (i[0] ? INV : 16'h0000) | (i[1] ? IDL : 16'h0000);
      wr(CTL, cb);
      repeat (2) @(posedge core_clk);
      chk("off level", 32'(i[0] ^ i[1]), 32'(pin));
    end
    wr(CA, 16'h0002);
    wr(CB, 16'h0005);
    wr(CTL, 16'h0000);
    wr(CTL, CLR);
    chk("wave after clear", 0, pin);
    wr(CTL, RUN | OEN);
    n = 0;
    while (pin !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    chk("wave high", 1, pin);
    n = 0;
    while (pin !== 1'b0 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    chk("wave low", 0, pin);
    wr(CTL, 16'h0000);
    $display("test waveform pin done");
  endtask

  // ==========================================================
  // Verdict and main sequence
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_reserved();
    t_run_stop();
    t_tap();
    t_ext();
    t_irq();
    t_pin();
    give_verdict();
  end
endmodule
